/* hdl/exec_seq_map.svh */
// Constants for the execute-remote-instruction sequencer
// Notes on behaviour
// - The execute command's effective operand address names the next instruction to fetch and run.
// - The program counter is not advanced while the execute command is handled.
// - Any instruction, another execute command included, may be the object.
// - A relative object computes its operand from its own location, not the program counter.
// - The execute command's ordinary fetch sets the pending flag on its last pulse envelope.
// - While the pending flag is set the next fetch addresses memory from the low operand bits.
// - A second fetch whose word is not an execute command clears the pending flag at its last pulse and goes to execution.
// - The execute command itself takes one fetch state only.
// - No program interrupt is accepted between the execute command and its object.
// - A normal fetch passes the low address bits into the operand register, through the adder only when the relative bit is set.
`ifndef EXEC_SEQ_MAP_SVH
`define EXEC_SEQ_MAP_SVH
`define WORD_W        24
`define ADDR_W        14
`define OPC_HI        23
`define OPC_LO        18
`define OPC_EXEC      6'h04
`define REL_BIT       14
`define FETCH_PULSES  4'h4
`define ADDR_RST      14'h0000
`endif

/* hdl/exec_seq_pkg.sv */
// Types for the execute-remote-instruction sequencer
package exec_seq_pkg;
    typedef struct packed {
        logic        req;
        logic [13:0] addr;
    } mem_req_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXEC  = 3'b100
    } seq_state_t;
endpackage

/* hdl/exec_seq.sv */
// Fetch sequencer with execute-remote-instruction redirection
`timescale 1ns/1ps
`include "exec_seq_map.svh"
module exec_seq #(
    parameter int PULSES = `FETCH_PULSES
) (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    // Sequence control
    input  wire logic                   fetch_start_i,
    input  wire logic                   exec_done_i,
    input  wire logic                   irq_i,
    input  wire logic [13:0]            pc_i,
    // Core memory
    input  wire logic                   mem_ack_i,
    input  wire logic [23:0]            mem_data_i,
    output exec_seq_pkg::mem_req_t      mem_o,
    // Toward execution states
    output logic                        execute_pending_flag_o,
    output logic                        memory_addr_from_operand_sel_o,
    output logic                        pc_advance_o,
    output logic                        exec_start_o,
    output logic [23:0]                 instr_o,
    output logic [13:0]                 operand_o,
    output logic                        irq_accept_o
);
    import exec_seq_pkg::*;

    // Four-bit pulse counter: a longer envelope would wrap the compare value and end a fetch early
    if (PULSES < 1 || PULSES > 15) begin : g_bad_pulses
        $error("PULSES out of range");
    end

    seq_state_t  state;
    seq_state_t  next_state;
    logic [3:0]  pulse;
    logic [13:0] operand_reg;
    // Where the latest word came from; a relative object counts from here
    logic [13:0] instr_loc;
    logic        flag;

    // Decode of the fetched word, used in several places
    function automatic logic is_exec(input logic [23:0] w);
        return w[`OPC_HI:`OPC_LO] == `OPC_EXEC;
    endfunction

    wire last_pulse = (state == ST_FETCH) && mem_ack_i && (pulse == 4'(PULSES - 1));
    wire word_exec  = is_exec(mem_data_i);
    wire [13:0] fetch_addr = flag ? operand_reg : pc_i;
    // adder path; relative from own location
    // Base is the fetch address, so a redirected object never sees the PC
    wire [13:0] eff_addr = mem_data_i[`REL_BIT]
                         ? 14'(fetch_addr + mem_data_i[`ADDR_W-1:0])
                         : mem_data_i[`ADDR_W-1:0];

    // State selection
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (fetch_start_i) next_state = ST_FETCH;
            // one fetch then refetch; any object
            ST_FETCH: if (last_pulse) next_state = word_exec ? ST_FETCH : ST_EXEC;
            ST_EXEC:  if (exec_done_i) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // Pulse counter runs through each fetch envelope
    always_ff @(posedge clock_i) begin
        if (rst_i || state != ST_FETCH || last_pulse) pulse <= 4'h0;
        else if (mem_ack_i) pulse <= pulse + 4'h1;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            flag        <= 1'b0;
            operand_reg <= `ADDR_RST;
            instr_loc   <= `ADDR_RST;
            instr_o     <= 24'h000000;
        end else begin
            state <= next_state;
            if (last_pulse) begin
                operand_reg <= eff_addr;
                instr_loc   <= fetch_addr;
                instr_o     <= mem_data_i;
                flag        <= word_exec;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mem_o                          <= '0;
            execute_pending_flag_o         <= 1'b0;
            memory_addr_from_operand_sel_o <= 1'b0;
            pc_advance_o                   <= 1'b0;
            exec_start_o                   <= 1'b0;
            operand_o                      <= `ADDR_RST;
            irq_accept_o                   <= 1'b0;
        end else begin
            mem_o.req                      <= (next_state == ST_FETCH);
            mem_o.addr                     <= (last_pulse && word_exec) ? eff_addr : fetch_addr;
            execute_pending_flag_o         <= last_pulse ? word_exec : flag;
            memory_addr_from_operand_sel_o <= last_pulse ? word_exec : flag;
            // no advance for the execute word
            // Only the object's fetch steps the PC, once, past the execute command
            pc_advance_o                   <= last_pulse && !word_exec;
            exec_start_o                   <= last_pulse && !word_exec;
            operand_o                      <= last_pulse ? eff_addr : operand_reg;
            irq_accept_o                   <= irq_i && state == ST_IDLE && !flag;
        end
    end

    // Checks
    property p_flag_set;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && word_exec |=> flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_flag_clr;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && !word_exec |=> !flag ##0 state == ST_EXEC;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_redirect;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && word_exec |=> mem_o.addr == operand_reg;
    endproperty
    a_redirect: assert property (p_redirect) else $error("bad redirect");
    property p_no_adv;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && word_exec |=> !pc_advance_o;
    endproperty
    a_no_adv: assert property (p_no_adv) else $error("pc advanced");
    property p_no_irq;
        @(posedge clock_i) disable iff (rst_i)
        flag |=> !irq_accept_o;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq accepted");
    property p_one_fetch;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && word_exec |=> state == ST_FETCH;
    endproperty
    a_one_fetch: assert property (p_one_fetch) else $error("extra state");
    property p_operand;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse |=> operand_o == operand_reg;
    endproperty
    a_operand: assert property (p_operand) else $error("operand mismatch");
    property p_chain;
        @(posedge clock_i) disable iff (rst_i)
        flag && last_pulse && word_exec |=> flag;
    endproperty
    a_chain: assert property (p_chain) else $error("chain lost");
    property p_abs_operand;
        @(posedge clock_i) disable iff (rst_i)
        exec_start_o && !instr_o[`REL_BIT] |-> operand_o == instr_o[`ADDR_W-1:0];
    endproperty
    a_abs_operand: assert property (p_abs_operand) else $error("bad operand");
    property p_rel_base;
        @(posedge clock_i) disable iff (rst_i)
        exec_start_o && instr_o[`REL_BIT]
            |-> operand_o == 14'(instr_loc + instr_o[`ADDR_W-1:0]);
    endproperty
    a_rel_base: assert property (p_rel_base) else $error("bad relative base");
    property p_rel_loc;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && flag |=> instr_loc == $past(operand_reg);
    endproperty
    a_rel_loc: assert property (p_rel_loc) else $error("bad object location");
    property p_any_object;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && flag && !word_exec |=> exec_start_o && state == ST_EXEC;
    endproperty
    a_any_object: assert property (p_any_object) else $error("object lost");
    property p_operand_fetch;
        @(posedge clock_i) disable iff (rst_i)
        flag && mem_o.req
            |-> memory_addr_from_operand_sel_o && mem_o.addr == operand_reg;
    endproperty
    a_operand_fetch: assert property (p_operand_fetch) else $error("bad fetch addr");
    property p_adv_once;
        @(posedge clock_i) disable iff (rst_i)
        last_pulse && !word_exec |=> pc_advance_o ##1 !pc_advance_o;
    endproperty
    a_adv_once: assert property (p_adv_once) else $error("bad pc advance");
    property p_start_pulse;
        @(posedge clock_i) disable iff (rst_i)
        exec_start_o |=> !exec_start_o && !flag;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("bad start pulse");
    property p_pulse_bound;
        @(posedge clock_i) disable iff (rst_i)
        state == ST_FETCH |-> pulse < 4'(PULSES);
    endproperty
    a_pulse_bound: assert property (p_pulse_bound) else $error("pulse overrun");
    property p_busy_irq;
        @(posedge clock_i) disable iff (rst_i)
        state != ST_IDLE |=> !irq_accept_o;
    endproperty
    a_busy_irq: assert property (p_busy_irq) else $error("irq while busy");
    c_exec: cover property (@(posedge clock_i) last_pulse && word_exec);
    c_chain: cover property (@(posedge clock_i) flag && last_pulse && word_exec);
    c_plain: cover property (@(posedge clock_i) !flag && last_pulse && !word_exec);
    c_rel_obj: cover property (@(posedge clock_i) flag && last_pulse && mem_data_i[`REL_BIT]);
endmodule // exec_seq

/* bench/mem_model.sv */
// Core memory partner answering fetch requests with data envelopes
`timescale 1ns/1ps
module mem_model (
    // Clock and fetch request
    input  wire logic                   clock_i,
    input  wire exec_seq_pkg::mem_req_t mem_i,
    input  wire logic                   slow_i,
    // Answer
    output logic                        ack_o,
    output logic [23:0]                 data_o
);
    import exec_seq_pkg::*;
    logic [23:0] mem [16];
    logic [23:0] last = 24'h000000;
    logic        gap  = 1'b0;
    // Slow mode skips every other envelope; idle data is scrambled
    assign ack_o  = mem_i.req && !(slow_i && gap);
    assign data_o = ack_o ? mem[mem_i.addr[3:0]] : ~last;
    always @(posedge clock_i) begin
        gap  <= ~gap;
        last <= data_o;
    end
endmodule // mem_model

/* bench/tb_top.sv */
// Random and corner-case bench for the execute sequencer
`timescale 1ns/1ps
`include "exec_seq_map.svh"
module tb_top;
    import exec_seq_pkg::*;
    logic        clock_i = 1'b0, rst_i = 1'b1, fetch_start_i = 1'b0, exec_done_i = 1'b0;
    logic        irq_i = 1'b0, slow = 1'b0, mem_ack_i, flag, sel, adv, start, irq_ok;
    logic [13:0] pc_i = 14'h0000, operand_o;
    logic [23:0] mem_data_i, instr_o, acks, nadv, nfl;
    logic [13:0] fa [3];
    logic [15:0] lf = 16'h0005;
    mem_req_t    mem_o;
    int          mismatches = 0, checks_done = 0;
    exec_seq #(.PULSES(4)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .fetch_start_i(fetch_start_i), .exec_done_i(exec_done_i), .irq_i(irq_i),
        .pc_i(pc_i), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .mem_o(mem_o),
        .execute_pending_flag_o(flag), .memory_addr_from_operand_sel_o(sel),
        .pc_advance_o(adv), .exec_start_o(start), .instr_o(instr_o),
        .operand_o(operand_o), .irq_accept_o(irq_ok));
    mem_model mem_u (.clock_i(clock_i), .mem_i(mem_o), .slow_i(slow),
        .ack_o(mem_ack_i), .data_o(mem_data_i));
    initial forever #5 clock_i = ~clock_i;
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Relative objects count from their own location, others take the field
    function automatic logic [13:0] exp_operand(input int kind, input logic [13:0] loc,
                                                input logic [13:0] f);
        return (kind == 3) ? 14'(loc + f) : f;
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Fetch address log, envelope count and guard on the pending window
    always @(posedge clock_i) begin
        if (mem_ack_i && mem_o.req && acks < 12) fa[acks / 4] = mem_o.addr;
        if (mem_ack_i && mem_o.req) acks++;
        if (mem_ack_i && mem_o.req && flag) nfl++;
        nadv += adv;
        if (flag) begin
            check(irq_ok, 1'b0);
            check(sel, 1'b1);
        end
    end
    // Kind 0 plain, 1 one redirect, 2 chained redirect, 3 relative object
    task automatic run(input int kind);
        logic [13:0] pc, z1, z2, f;
        logic [23:0] obj;
        int          n;
        lf = nx(lf);
        pc = {12'h000, lf[1:0]};
        z1 = {12'h002, lf[3:2]};
        z2 = {12'h003, lf[5:4]};
        f = lf[15:2];
        slow = lf[6];
        obj = {6'h01, 3'h0, kind == 3, f};
        n = (kind == 0) ? 1 : (kind == 2) ? 3 : 2;
        mem_u.mem[pc[3:0]] = (kind == 0) ? obj : {`OPC_EXEC, 4'h0, z1};
        mem_u.mem[z1[3:0]] = (kind == 2) ? {`OPC_EXEC, 4'h0, z2} : obj;
        mem_u.mem[z2[3:0]] = obj;
        pc_i = pc;
        acks = '0;
        nadv = '0;
        nfl = '0;
        fetch_start_i = 1'b1;
        @(posedge clock_i) #1 fetch_start_i = 1'b0;
        for (int c = 0; c < 200 && start !== 1'b1; c++) begin
            irq_i = lf[c % 16];
            @(posedge clock_i) #1;
        end
        check(start, 1'b1);
        check(instr_o, obj);
        check(operand_o, exp_operand(kind, z1, f));
        @(posedge clock_i) #1 exec_done_i = 1'b1;
        @(posedge clock_i) #1 exec_done_i = 1'b0;
        check(nadv, 24'h000001);
        check(acks, 24'(n * 4));
        check(nfl, 24'((n - 1) * 4));
        check(fa[0], pc);
        check(fa[n - 1], (n == 1) ? pc : (n == 2) ? z1 : z2);
        irq_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #1 check(irq_ok, 1'b1);
        irq_i = 1'b0;
        $display("test kind %0d slow %0d done", kind, slow);
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        #1 rst_i = 1'b0;
        check({9'h000, mem_o}, 24'h000000);
        for (int i = 0; i < 24; i++) run(i % 4);
        end_of_test();
    end
    // Watchdog far beyond 24 tests of at most about 30 cycles each
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
endmodule // tb_top
